// *** verilog/bops_defines.vh ***
/*
 * register map, field positions, reset values and operation codes of the
 * blit operation and address setup block.
 * assumes: included by bare name; byte addresses are four times the index.
 */
`ifndef BOPS_DEFINES_VH
`define BOPS_DEFINES_VH

// register indices as printed; byte address is index times four
`define BOPS_IDX_OPSEL     12'h103
`define BOPS_IDX_SRC_LO    12'h104
`define BOPS_IDX_SRC_MID   12'h105
`define BOPS_IDX_SRC_HI    12'h106
`define BOPS_IDX_DST_LO    12'h108
`define BOPS_IDX_DST_MID   12'h109
`define BOPS_IDX_DST_HI    12'h10A
`define BOPS_IDX_CFG       12'h10E
`define BOPS_IDX_STATUS    12'h10F

// config register fields
`define BOPS_CFG_BPP16_BIT   0
`define BOPS_CFG_CPUSRC_BIT  1

// reset values
`define BOPS_RST_BYTE      8'h00
`define BOPS_RST_OP        4'hF

// operation codes
`define BOPS_OP_WRITE_ROP    4'h0
`define BOPS_OP_READ         4'h1
`define BOPS_OP_MOVE_FWD     4'h2
`define BOPS_OP_MOVE_BWD     4'h3
`define BOPS_OP_TWRITE       4'h4
`define BOPS_OP_TMOVE_FWD    4'h5
`define BOPS_OP_PFILL_ROP    4'h6
`define BOPS_OP_PFILL_TRANS  4'h7
`define BOPS_OP_CEXP         4'h8
`define BOPS_OP_CEXP_TRANS   4'h9
`define BOPS_OP_MCEXP        4'hA
`define BOPS_OP_MCEXP_TRANS  4'hB
`define BOPS_OP_SOLID        4'hC

`endif

// *** verilog/bops_setup.v ***
/*
 * blit operation and address setup: apb register slave holding the operation
 * selector, source and destination start addresses, plus decoded operation
 * class flags and the pattern-fill split of the source address.
 * assumes: a single clock, apb master per amba apb protocol, blit datapath
 * downstream consumes the decoded outputs.
 */
// Added by the designer: the APB slave port.
`timescale 1ns/100ps
`include "bops_defines.vh"

module bops_setup #(
   parameter ADDR_W = 12
) (
   input  wire              clk_i,
   input  wire              rst_i,
   input  wire              psel_i,
   input  wire              penable_i,
   input  wire              pwrite_i,
   input  wire [ADDR_W-1:0] paddr_i,
   input  wire [31:0]       pwdata_i,
   output reg  [31:0]       prdata_o,
   output reg               pready_o,
   output reg               pslverr_o,
   output reg  [3:0]        op_code_o,
   output reg               op_valid_o,
   output reg               op_uses_rop_o,
   output reg               op_transparent_o,
   output reg               op_pattern_o,
   output reg               op_color_expand_o,
   output reg               op_move_o,
   output reg               op_backward_o,
   output reg               op_read_o,
   output reg               op_solid_o,
   output reg               op_host_source_o,
   output reg  [20:0]       src_addr_o,
   output reg  [20:0]       dst_addr_o,
   output reg               dst_bottom_right_o,
   output reg  [20:0]       pat_base_o,
   output reg  [2:0]        pat_line_o,
   output reg  [3:0]        pat_pixel_o,
   output reg               byte_align_o
);

   reg [3:0]  op_ff;
   reg [7:0]  src_lo_ff;
   reg [7:0]  src_mid_ff;
   reg [4:0]  src_hi_ff;
   reg [7:0]  dst_lo_ff;
   reg [7:0]  dst_mid_ff;
   reg [4:0]  dst_hi_ff;
   reg [1:0]  cfg_ff;

   wire [9:0]  idx;
   wire        addr_ok;
   wire        access;
   wire        wr_en;
   wire [20:0] src_addr;
   wire [20:0] dst_addr;
   reg  [31:0] nxt_rdata;
   reg  [9:0]  flags;

   // operation class decode: valid, rop, trans, pattern, cexp, move, bwd, read, solid, host
   function [9:0] op_decode;
      input [3:0] op;
      begin
         case (op)
            `BOPS_OP_WRITE_ROP:   op_decode = 10'b1100000001;
            `BOPS_OP_READ:        op_decode = 10'b1000000100;
            `BOPS_OP_MOVE_FWD:    op_decode = 10'b1100010000;
            `BOPS_OP_MOVE_BWD:    op_decode = 10'b1100011000;
            `BOPS_OP_TWRITE:      op_decode = 10'b1010000001;
            `BOPS_OP_TMOVE_FWD:   op_decode = 10'b1010010000;
            `BOPS_OP_PFILL_ROP:   op_decode = 10'b1101000000;
            `BOPS_OP_PFILL_TRANS: op_decode = 10'b1011000000;
            `BOPS_OP_CEXP:        op_decode = 10'b1000100001;
            `BOPS_OP_CEXP_TRANS:  op_decode = 10'b1010100001;
            `BOPS_OP_MCEXP:       op_decode = 10'b1000110000;
            `BOPS_OP_MCEXP_TRANS: op_decode = 10'b1010110000;
            `BOPS_OP_SOLID:       op_decode = 10'b1000000010;
            default:              op_decode = 10'b0000000000;
         endcase
      end
   endfunction

   // word index from byte address
   assign idx     = paddr_i[11:2];
   assign addr_ok = (paddr_i[1:0] == 2'b00) &&
                    ((idx == `BOPS_IDX_OPSEL)  || (idx == `BOPS_IDX_SRC_LO) ||
                     (idx == `BOPS_IDX_SRC_MID) || (idx == `BOPS_IDX_SRC_HI) ||
                     (idx == `BOPS_IDX_DST_LO) || (idx == `BOPS_IDX_DST_MID) ||
                     (idx == `BOPS_IDX_DST_HI) || (idx == `BOPS_IDX_CFG) ||
                     (idx == `BOPS_IDX_STATUS));
   // access phase completes on the cycle pready_o is high
   assign access  = psel_i && penable_i && pready_o;
   assign wr_en   = access && pwrite_i && addr_ok;

   assign src_addr = {src_hi_ff, src_mid_ff, src_lo_ff};
   assign dst_addr = {dst_hi_ff, dst_mid_ff, dst_lo_ff};

   always @* begin
      flags = op_decode(op_ff);
   end

   // register write path
   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         op_ff      <= `BOPS_RST_OP;
         src_lo_ff  <= `BOPS_RST_BYTE;
         src_mid_ff <= `BOPS_RST_BYTE;
         src_hi_ff  <= 5'h00;
         dst_lo_ff  <= `BOPS_RST_BYTE;
         dst_mid_ff <= `BOPS_RST_BYTE;
         dst_hi_ff  <= 5'h00;
         cfg_ff     <= 2'h0;
      end else if (wr_en) begin
         case (idx)
            `BOPS_IDX_OPSEL:   op_ff      <= pwdata_i[3:0];
            `BOPS_IDX_SRC_LO:  src_lo_ff  <= pwdata_i[7:0];
            `BOPS_IDX_SRC_MID: src_mid_ff <= pwdata_i[7:0];
            `BOPS_IDX_SRC_HI:  src_hi_ff  <= pwdata_i[4:0];
            `BOPS_IDX_DST_LO:  dst_lo_ff  <= pwdata_i[7:0];
            `BOPS_IDX_DST_MID: dst_mid_ff <= pwdata_i[7:0];
            `BOPS_IDX_DST_HI:  dst_hi_ff  <= pwdata_i[4:0];
            `BOPS_IDX_CFG:     cfg_ff     <= pwdata_i[1:0];
            default:           cfg_ff     <= cfg_ff;
         endcase
      end
   end

   // read mux
   always @* begin
      nxt_rdata = 32'h00000000;
      case (idx)
         `BOPS_IDX_OPSEL:   nxt_rdata = {28'h0000000, op_ff};
         `BOPS_IDX_SRC_LO:  nxt_rdata = {24'h000000, src_lo_ff};
         `BOPS_IDX_SRC_MID: nxt_rdata = {24'h000000, src_mid_ff};
         `BOPS_IDX_SRC_HI:  nxt_rdata = {27'h0000000, src_hi_ff};
         `BOPS_IDX_DST_LO:  nxt_rdata = {24'h000000, dst_lo_ff};
         `BOPS_IDX_DST_MID: nxt_rdata = {24'h000000, dst_mid_ff};
         `BOPS_IDX_DST_HI:  nxt_rdata = {27'h0000000, dst_hi_ff};
         `BOPS_IDX_CFG:     nxt_rdata = {30'h00000000, cfg_ff};
         `BOPS_IDX_STATUS:  nxt_rdata = {22'h000000, flags};
         default:           nxt_rdata = 32'h00000000;
      endcase
   end

   // apb handshake: one wait state, answer in the second access cycle
   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         pready_o  <= 1'b0;
         prdata_o  <= 32'h00000000;
         pslverr_o <= 1'b0;
      end else begin
         pready_o  <= psel_i && penable_i && !pready_o;
         pslverr_o <= psel_i && penable_i && !pready_o && !addr_ok;
         if (psel_i && penable_i && !pready_o && !pwrite_i && addr_ok) begin
            prdata_o <= nxt_rdata;
         end else if (pready_o) begin
            prdata_o <= 32'h00000000;
         end
      end
   end

   // decoded outputs toward the blit datapath
   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         op_code_o          <= `BOPS_RST_OP;
         op_valid_o         <= 1'b0;
         op_uses_rop_o      <= 1'b0;
         op_transparent_o   <= 1'b0;
         op_pattern_o       <= 1'b0;
         op_color_expand_o  <= 1'b0;
         op_move_o          <= 1'b0;
         op_backward_o      <= 1'b0;
         op_read_o          <= 1'b0;
         op_solid_o         <= 1'b0;
         op_host_source_o   <= 1'b0;
         src_addr_o         <= 21'h000000;
         dst_addr_o         <= 21'h000000;
         dst_bottom_right_o <= 1'b0;
         pat_base_o         <= 21'h000000;
         pat_line_o         <= 3'h0;
         pat_pixel_o        <= 4'h0;
         byte_align_o       <= 1'b0;
      end else begin
         op_code_o          <= op_ff;
         op_valid_o         <= flags[9];
         op_uses_rop_o      <= flags[8];
         op_transparent_o   <= flags[7];
         op_pattern_o       <= flags[6];
         op_color_expand_o  <= flags[5];
         op_move_o          <= flags[4];
         op_backward_o      <= flags[3];
         op_read_o          <= flags[2];
         op_solid_o         <= flags[1];
         op_host_source_o   <= flags[0] && cfg_ff[`BOPS_CFG_CPUSRC_BIT];
         dst_addr_o         <= dst_addr;
         dst_bottom_right_o <= flags[3];
         if (flags[0] && cfg_ff[`BOPS_CFG_CPUSRC_BIT]) begin
            src_addr_o <= {20'h00000, src_addr[0]};
         end else begin
            src_addr_o <= src_addr;
         end
         byte_align_o       <= src_addr[0];
         if (cfg_ff[`BOPS_CFG_BPP16_BIT]) begin
            pat_base_o  <= {src_addr[20:7], 7'h00};
            pat_line_o  <= src_addr[6:4];
            pat_pixel_o <= src_addr[3:0];
         end else begin
            pat_base_o  <= {src_addr[20:6], 6'h00};
            pat_line_o  <= src_addr[5:3];
            pat_pixel_o <= {1'b0, src_addr[2:0]};
         end
      end
   end

endmodule // bops_setup

// *** dv/bops_setup_props.sv ***
/* checker: bus answer and decode relations of the setup block.
   assumes: bound to bops_setup, one clock, reset active high. */
`timescale 1ns/100ps
module bops_setup_props #(parameter ADDR_W = 12) (
   input wire              clk_i, rst_i, psel_i, penable_i, pwrite_i,
   input wire [ADDR_W-1:0] paddr_i,
   input wire [31:0]       pwdata_i,
   input wire              pready_o, pslverr_o, op_valid_o, op_pattern_o,
   input wire              op_host_source_o, dst_bottom_right_o, byte_align_o,
   input wire [3:0]        op_code_o, pat_pixel_o,
   input wire [20:0]       src_addr_o, pat_base_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   wire       wr_op = psel_i && penable_i && pready_o && pwrite_i && paddr_i == 12'h40C;
   wire [3:0] wd    = pwdata_i[3:0];
   AST_ANS: assert property (psel_i && $rose(penable_i) |=> pready_o)
      else $error("no answer in second access cycle");
   AST_OPWR: assert property (wr_op |=> ##1 op_code_o == $past(wd, 2))
      else $error("selector not taken from write");
   AST_VAL: assert property (op_valid_o == (op_code_o <= 4'hC))
      else $error("valid flag wrong");
   AST_PAT: assert property (op_pattern_o == (op_code_o[3:1] == 3'h3))
      else $error("pattern flag wrong");
   AST_BWD: assert property (dst_bottom_right_o == (op_code_o == 4'h3))
      else $error("corner flag wrong");
   AST_HOST: assert property (op_host_source_o |-> src_addr_o[20:1] == 20'h0)
      else $error("host source keeps high bits");
   AST_ALN: assert property (byte_align_o == src_addr_o[0])
      else $error("alignment bit wrong");
   AST_PIX: assert property (op_pattern_o |-> pat_pixel_o[2:0] == src_addr_o[2:0])
      else $error("pixel offset wrong");
   AST_BASE: assert property (op_pattern_o |-> pat_base_o[5:0] == 6'h0
      && pat_base_o[20:7] == src_addr_o[20:7])
      else $error("pattern base wrong");
   cover property (op_pattern_o);
   cover property (op_host_source_o);
   cover property (pslverr_o);
endmodule // bops_setup_props
bind bops_setup bops_setup_props #(.ADDR_W(ADDR_W)) u_props (.*);

// *** dv/bops_mem_model.sv ***
/* display memory side: records the last defined operation handed over.
   assumes: decoded outputs of the setup block, same clock. */
`timescale 1ns/100ps
module bops_mem_model (
   input  wire        clk_i,
   input  wire        rst_i,
   input  wire        op_valid_i,
   input  wire [3:0]  op_code_i,
   input  wire [20:0] dst_addr_i,
   output wire [3:0]  last_op_o,
   output wire [20:0] last_dst_o
);
   reg [3:0]  last_op_ff;
   reg [20:0] last_dst_ff;
   assign last_op_o  = last_op_ff;
   assign last_dst_o = last_dst_ff;
   // reserved codes never reach memory
   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         last_op_ff  <= 4'hF;
         last_dst_ff <= 21'h0;
      end else if (op_valid_i) begin
         last_op_ff  <= op_code_i;
         last_dst_ff <= dst_addr_i;
      end
   end
endmodule // bops_mem_model

// *** dv/bops_setup_tb_top.sv ***
/* testbench: apb register tests of the blit setup block.
   assumes: apb slave answers with pready_o, decode follows two edges later. */
`timescale 1ns/100ps
module bops_setup_tb_top;
   reg          clk_i = 0, rst_i = 1, psel_i = 0, penable_i = 0, pwrite_i = 0;
   reg  [11:0]  paddr_i = 12'h000;
   reg  [31:0]  pwdata_i = 32'h0, rd;
   reg          er;
   reg  [3:0]   c;
   wire [31:0]  prdata_o;
   wire         pready_o, pslverr_o, op_valid_o, op_uses_rop_o, op_transparent_o;
   wire         op_pattern_o, op_color_expand_o, op_move_o, op_backward_o, op_read_o;
   wire         op_solid_o, op_host_source_o, dst_bottom_right_o, byte_align_o;
   wire [3:0]   op_code_o, pat_pixel_o, m_op;
   wire [20:0]  src_addr_o, dst_addr_o, pat_base_o, m_dst;
   wire [2:0]   pat_line_o;
   integer      bad_count = 0, cmp_count = 0, i;
   localparam [15:0] RASTER_OPERATION = 16'h004D, TRN = 16'h0AB0, PAT = 16'h00C0, CX = 16'h0F00;
   localparam [15:0] MV = 16'h0C2C;
   localparam [20:0] S = 21'h1F5AA5;
   bops_setup dut (.*);
   bops_mem_model mdl (.clk_i(clk_i), .rst_i(rst_i), .op_valid_i(op_valid_o),
      .op_code_i(op_code_o), .dst_addr_i(dst_addr_o), .last_op_o(m_op), .last_dst_o(m_dst));
   initial forever #5 clk_i = ~clk_i;
   task wrap_up;
      begin
         $display("compares %0d mismatches %0d", cmp_count, bad_count);
         if (bad_count == 0 && cmp_count > 0)
            $display("Finished cleanly");
         else
            $display("Finished with errors");
         $finish;
      end
   endtask
   task chk(input [31:0] seen, input [31:0] exp);
      begin
         cmp_count = cmp_count + 1;
         if (seen !== exp) begin
            bad_count = bad_count + 1;
            $display("BAD at %0t: saw %h want %h", $time, seen, exp);
         end
      end
   endtask
   task xfer(input w, input [11:0] a, input [31:0] d);
      integer n;
      begin
         @(posedge clk_i);
         psel_i <= 1;
         pwrite_i <= w;
         paddr_i <= a;
         pwdata_i <= d;
         @(posedge clk_i);
         penable_i <= 1;
         n = 0;
         do begin
            @(posedge clk_i);
            n = n + 1;
         end while (pready_o !== 1'b1);
         rd = prdata_o;
         er = pslverr_o;
         psel_i <= 0;
         penable_i <= 0;
      end
   endtask
   task wset(input [11:0] a, input [31:0] d);
      begin
         xfer(1, a, d);
         repeat (2) @(posedge clk_i);
         #1;
      end
   endtask
   initial begin
      #200000;
      bad_count = bad_count + 1;
      wrap_up;
   end
   initial begin
      repeat (8) @(posedge clk_i);
      rst_i <= 0;
      #1;
      chk({op_code_o, op_valid_o}, 5'h1E);
      $display("test reset done");
      for (i = 0; i < 16; i = i + 1) begin
         c = i[3:0];
         wset(12'h40C, {28'hABCDEF0, c});
         chk({op_valid_o, op_uses_rop_o, op_transparent_o, op_pattern_o, op_color_expand_o,
            op_move_o, op_read_o, op_solid_o, dst_bottom_right_o, op_backward_o, op_code_o},
            {c <= 4'hC, RASTER_OPERATION[c], TRN[c], PAT[c], CX[c], MV[c], c == 4'h1, c == 4'hC,
            c == 4'h3, c == 4'h3, c});
         xfer(0, 12'h40C, 32'h0);
         chk(rd, {28'h0, c});
      end
      chk(m_op, 4'hC);
      $display("test operation codes done");
      wset(12'h410, 32'hFFFFFFA5);
      wset(12'h414, 32'h0000005A);
      wset(12'h418, 32'h000000FF);
      chk(src_addr_o, S);
      xfer(0, 12'h418, 32'h0);
      chk(rd, 32'h1F);
      wset(12'h420, 32'h3C);
      wset(12'h424, 32'hC3);
      wset(12'h428, 32'h15);
      chk(dst_addr_o, 21'h15C33C);
      $display("test addresses done");
      wset(12'h40C, 32'h6);
      chk({pat_base_o, pat_line_o, pat_pixel_o}, {S[20:6], 6'h0, S[5:3], 1'b0, S[2:0]});
      wset(12'h438, 32'h1);
      chk({pat_base_o, pat_line_o, pat_pixel_o}, {S[20:7], 7'h0, S[6:4], S[3:0]});
      chk(m_dst, 21'h15C33C);
      chk(m_op, 4'h6);
      $display("test pattern split done");
      wset(12'h438, 32'h2);
      wset(12'h40C, 32'h0);
      chk({op_host_source_o, byte_align_o, src_addr_o}, {2'b11, 21'h1});
      $display("test host source done");
      xfer(0, 12'h400, 32'h0);
      chk(er, 1'b1);
      chk(rd, 32'h0);
      xfer(1, 12'h40D, 32'h5);
      chk(er, 1'b1);
      repeat (2) @(posedge clk_i);
      #1;
      chk(op_code_o, 4'h0);
      $display("test refusal done");
      wrap_up;
   end
endmodule // bops_setup_tb_top
